/* cqr_pkg.sv */
// Package of constants and types for the capability query responder
// Notes on behaviour
// - Command type 0x16 is recognised as the capability discovery request.
// - An error-free capability request is always answered with type 0x96.
// - Response fields sit at their fixed byte offsets, checksum at 48-51.
// - Word 40-43 holds four filter counts; word 44-47 reserved, VLAN modes, channels.
// - Flag bit 0 reports hardware arbitration, bit 1 host driver status.
// - Flag bit 2 reports controller-to-manager flow control support.
// - Flag bit 3 reports manager-to-controller flow control support.
// - Flag bit 4 reports all-multicast support; bits 31-5 are zero.
// - Broadcast mask bit set exactly when that broadcast filter is supported.
// - Multicast mask bit set exactly when that multicast filter is supported.
// - Buffering word gives manager-bound buffer bytes; zero means unspecified.
// - Event support word uses the notification control bit layout.
// - VLAN filter count never exceeds 15.
// - At least one unicast or mixed filter is always present.
// - Unicast, multicast and mixed counts add up to at most 8.
// - VLAN mode bit 0 is one, bits 1-2 optional, bits 7-3 zero.
// - Channel count reports channels in the package.
// - Parameter readback request carries type 0x17 with the same layout.
// - Parameter readback returns every setting currently in effect.
// - Each setting field returns the last stored value; filter count fields are fixed; unsupported fields read zero.
package cqr_pkg;
  // Request and response framing
  localparam logic [7:0] CMD_GET_CAP    = 8'h16;
  localparam logic [7:0] CMD_GET_PARAM  = 8'h17;
  localparam logic [7:0] RESP_BIT       = 8'h80;
  localparam int         HDR_LEN        = 16;
  localparam logic [5:0] TYPE_POS       = 6'h04;
  localparam logic [5:0] REQ_LAST_POS   = 6'h2D;
  localparam logic [5:0] RESP_LAST_POS  = 6'h33;
  localparam logic [15:0] RESP_GENERIC  = 16'h0000;
  localparam logic [15:0] REASON_NONE   = 16'h0000;
  // Capability content
  localparam logic [31:0] CAP_FLAGS     = 32'h0000_0017;
  localparam logic [31:0] CAP_BCAST     = 32'h0000_000F;
  localparam logic [31:0] CAP_MCAST     = 32'h0000_0007;
  localparam logic [31:0] CAP_BUFFER    = 32'h0000_2000;
  localparam logic [31:0] CAP_AEN       = 32'h0000_0007;
  localparam logic [7:0]  CNT_VLAN      = 8'h04;
  localparam logic [7:0]  CNT_MIXED     = 8'h02;
  localparam logic [7:0]  CNT_MCAST     = 8'h02;
  localparam logic [7:0]  CNT_UCAST     = 8'h02;
  localparam logic [7:0]  CAP_VLAN_MODE = 8'h05;
  localparam logic [7:0]  CAP_CHANNELS  = 8'h01;
  // Register offsets
  localparam logic [7:0] REG_LINK       = 8'h00;
  localparam logic [7:0] REG_BCAST      = 8'h04;
  localparam logic [7:0] REG_CFG_FLAGS  = 8'h08;
  localparam logic [7:0] REG_FLOW       = 8'h0C;
  localparam logic [7:0] REG_VLAN_MODE  = 8'h10;
  localparam logic [7:0] REG_AEN        = 8'h14;
  localparam logic [7:0] REG_MAC_FLAGS  = 8'h18;
  localparam logic [7:0] REG_VLAN_FLAGS = 8'h1C;
  localparam logic [7:0] REG_COUNTS     = 8'h20;
  localparam logic [7:0] REG_STATE      = 8'h24;
  // Reset values and write masks
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [31:0] RST_VLAN_MODE = 32'h0000_0001;
  localparam logic [31:0] MASK_CFG      = 32'h0000_000F;
  localparam logic [31:0] MASK_FLOW     = 32'h0000_0003;
  localparam logic [31:0] MASK_VLAN_MD  = 32'h0000_0007;
  localparam logic [31:0] MASK_MAC      = 32'h0000_003F;
  localparam logic [31:0] MASK_VLAN_FL  = 32'h0000_000F;
  localparam logic [31:0] MASK_ALL      = 32'hFFFF_FFFF;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       err;
  } cqr_rx_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } cqr_tx_t;

  typedef enum logic [1:0] {
    ST_RECV = 2'b01,
    ST_SEND = 2'b10
  } cqr_state_t;
endpackage

/* cqr_cfg_reg.sv */
// Software-written configuration word with reset value and support mask
`timescale 1ns/1ps
`default_nettype none
module cqr_cfg_reg #(
  parameter logic [31:0] RST  = 32'h0000_0000,
  parameter logic [31:0] MASK = 32'hFFFF_FFFF
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Write side
  input  wire logic        we,
  input  wire logic [31:0] wdata,
  // Stored value
  output logic      [31:0] q
);
  // Unsupported bits never store, so they read back as zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST & MASK;
    end else if (we) begin
      q <= wdata & MASK;
    end
  end
endmodule
`default_nettype wire

/* cqr_tx_ser.sv */
// Response serialiser: walks byte positions and emits bytes most significant first
`timescale 1ns/1ps
`default_nettype none
module cqr_tx_ser (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // Control from the interpreter
  input  wire logic             start,
  input  wire logic [31:0]      word,
  output logic      [3:0]       word_idx,
  output logic                  done,
  // Byte stream out
  input  wire logic             tx_ready,
  output cqr_pkg::cqr_tx_t      tx
);
  logic [5:0] pos;
  logic [5:0] next_pos;
  logic [7:0] next_byte;

  always_comb begin
    next_pos = pos;
    if (start) begin
      next_pos = 6'h00;
    end else if (tx.valid && tx_ready && !tx.last) begin
      next_pos = pos + 6'h01;
    end
    word_idx = next_pos[5:2];
    unique case (next_pos[1:0])
      2'b00: next_byte = word[31:24];
      2'b01: next_byte = word[23:16];
      2'b10: next_byte = word[15:8];
      2'b11: next_byte = word[7:0];
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pos  <= 6'h00;
      tx   <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        pos       <= next_pos;
        tx.valid  <= 1'b1;
        tx.data   <= next_byte;
        tx.last   <= 1'b0;
      end else if (tx.valid && tx_ready) begin
        if (tx.last) begin
          tx.valid <= 1'b0;
          tx.last  <= 1'b0;
          done     <= 1'b1;
        end else begin
          pos     <= next_pos;
          tx.data <= next_byte;
          tx.last <= (next_pos == cqr_pkg::RESP_LAST_POS);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* cqr_top.sv */
// Capability and parameter readback command interpreter for one channel
`timescale 1ns/1ps
`default_nettype none
module cqr_top (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // Request byte stream from the sideband link
  input  wire cqr_pkg::cqr_rx_t rx,
  output logic                  rx_ready,
  // Response byte stream to the sideband link
  input  wire logic             tx_ready,
  output cqr_pkg::cqr_tx_t      tx,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_we,
  input  wire logic             reg_re,
  output logic      [31:0]      reg_rdata
);
  // Interpreter state
  cqr_pkg::cqr_state_t state;
  cqr_pkg::cqr_state_t next_state;

  // Request capture
  logic [7:0]  hdr [cqr_pkg::HDR_LEN];
  logic [5:0]  rx_pos;
  logic        frame_err;
  logic        rx_take;
  logic        frame_end;
  logic        frame_ok;
  logic        cmd_known;
  logic        accept;
  logic [7:0]  cur_type;

  // Response control
  logic        kind_param;
  logic        start;
  logic        ser_done;
  logic [3:0]  word_idx;
  logic [31:0] word;
  logic [31:0] hdr_word;
  logic [31:0] cap_word;
  logic [31:0] param_word;
  logic [7:0]  resp_type;
  logic [7:0]  mac_count;

  // Answered query counts
  logic [15:0] cap_count;
  logic [15:0] param_count;

  // Settings stored by the management side
  logic [31:0] cfg_link;
  logic [31:0] cfg_bcast;
  logic [31:0] cfg_flags;
  logic [31:0] cfg_flow;
  logic [31:0] cfg_vlan_mode;
  logic [31:0] cfg_aen;
  logic [31:0] cfg_mac_flags;
  logic [31:0] cfg_vlan_flags;

  // Register port decode
  logic        we_link;
  logic        we_bcast;
  logic        we_flags;
  logic        we_flow;
  logic        we_vlan_mode;
  logic        we_aen;
  logic        we_mac_flags;
  logic        we_vlan_flags;
  logic [31:0] next_rdata;

  // A byte moves when both sides agree
  assign rx_take   = rx.valid && rx_ready;
  assign frame_end = rx_take && rx.last;
  assign cur_type  = hdr[4'(cqr_pkg::TYPE_POS)];

  // Only the two query codes are answered here
  assign cmd_known = (cur_type == cqr_pkg::CMD_GET_CAP) ||
                     (cur_type == cqr_pkg::CMD_GET_PARAM);

  // Error-free frame of exactly the request length
  assign frame_ok = !rx.err && !frame_err && cmd_known &&
                    (rx_pos == cqr_pkg::REQ_LAST_POS);
  assign accept   = (state == cqr_pkg::ST_RECV) && frame_end && frame_ok;

  // Byte position within the request
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_pos <= 6'h00;
    end else if (rx_take) begin
      if (rx.last) begin
        rx_pos <= 6'h00;
      end else if (rx_pos != 6'h3F) begin
        rx_pos <= rx_pos + 6'h01;
      end
    end
  end

  // Sticky error over a frame; an overlong frame is an error too
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      frame_err <= 1'b0;
    end else if (rx_take) begin
      if (rx.last) begin
        frame_err <= 1'b0;
      end else if (rx.err || (rx_pos == 6'h3F)) begin
        frame_err <= 1'b1;
      end
    end
  end

  // Header bytes are kept for the answer header
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < cqr_pkg::HDR_LEN; i++) begin
        hdr[i] <= 8'h00;
      end
    end else if (rx_take && (rx_pos < 6'(cqr_pkg::HDR_LEN))) begin
      hdr[rx_pos[3:0]] <= rx.data;
    end
  end

  // Receive until a good query ends, then send its answer
  always_comb begin
    next_state = state;
    unique case (state)
      cqr_pkg::ST_RECV: begin
        if (accept) begin
          next_state = cqr_pkg::ST_SEND;
        end
      end
      cqr_pkg::ST_SEND: begin
        if (ser_done) begin
          next_state = cqr_pkg::ST_RECV;
        end
      end
      default: begin
        next_state = cqr_pkg::ST_RECV;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= cqr_pkg::ST_RECV;
    end else begin
      state <= next_state;
    end
  end

  // Requests are refused while an answer is going out
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= (next_state == cqr_pkg::ST_RECV);
    end
  end

  // One start pulse per accepted query
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      start <= 1'b0;
    end else begin
      start <= accept;
    end
  end

  // Answer kind and type code latched with the start pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      kind_param <= 1'b0;
      resp_type  <= 8'h00;
    end else if (accept) begin
      kind_param <= (cur_type == cqr_pkg::CMD_GET_PARAM);
      resp_type  <= cur_type | cqr_pkg::RESP_BIT;
    end
  end

  // Answered query counts, readable by software
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cap_count   <= 16'h0000;
      param_count <= 16'h0000;
    end else if (accept) begin
      if (cur_type == cqr_pkg::CMD_GET_PARAM) begin
        param_count <= param_count + 16'h0001;
      end else begin
        cap_count <= cap_count + 16'h0001;
      end
    end
  end

  // Header words echo the request with the answer type code
  always_comb begin
    hdr_word = 32'h0000_0000;
    unique case (word_idx[1:0])
      2'b00: hdr_word = {hdr[0], hdr[1], hdr[2], hdr[3]};
      2'b01: hdr_word = {resp_type, hdr[5], hdr[6], hdr[7]};
      2'b10: hdr_word = {hdr[8], hdr[9], hdr[10], hdr[11]};
      2'b11: hdr_word = {hdr[12], hdr[13], hdr[14], hdr[15]};
    endcase
  end

  // Capability answer echoes the request header in words 0-3; the rest comes only from fixed constants
  always_comb begin
    cap_word = 32'h0000_0000;
    unique case (word_idx)
      4'h0, 4'h1, 4'h2, 4'h3: cap_word = hdr_word;
      4'h4: cap_word = {cqr_pkg::RESP_GENERIC, cqr_pkg::REASON_NONE};
      4'h5: cap_word = cqr_pkg::CAP_FLAGS;
      4'h6: cap_word = cqr_pkg::CAP_BCAST;
      4'h7: cap_word = cqr_pkg::CAP_MCAST;
      4'h8: cap_word = cqr_pkg::CAP_BUFFER;
      4'h9: cap_word = cqr_pkg::CAP_AEN;
      4'hA: begin
        cap_word = {cqr_pkg::CNT_VLAN,
                    cqr_pkg::CNT_MIXED,
                    cqr_pkg::CNT_MCAST,
                    cqr_pkg::CNT_UCAST};
      end
      4'hB: begin
        cap_word = {16'h0000,
                    cqr_pkg::CAP_VLAN_MODE,
                    cqr_pkg::CAP_CHANNELS};
      end
      // Checksum word goes out as zero and is filled in further down the link
      default: cap_word = 32'h0000_0000;
    endcase
  end

  // Total address filters, unicast plus multicast plus mixed
  assign mac_count = cqr_pkg::CNT_UCAST + cqr_pkg::CNT_MCAST + cqr_pkg::CNT_MIXED;

  // Readback answer reflects the stored settings
  always_comb begin
    param_word = 32'h0000_0000;
    unique case (word_idx)
      4'h0, 4'h1, 4'h2, 4'h3: param_word = hdr_word;
      4'h4: param_word = {cqr_pkg::RESP_GENERIC, cqr_pkg::REASON_NONE};
      4'h5: param_word = {8'h00, mac_count, 8'h00, cfg_mac_flags[7:0]};
      4'h6: param_word = {cqr_pkg::CNT_VLAN, 8'h00, cfg_vlan_flags[15:0]};
      4'h7: param_word = cfg_link;
      4'h8: param_word = cfg_bcast;
      4'h9: param_word = cfg_flags;
      4'hA: param_word = {cfg_vlan_mode[7:0], 16'h0000, cfg_flow[7:0]};
      4'hB: param_word = cfg_aen;
      default: param_word = 32'h0000_0000;
    endcase
  end

  // Which answer feeds the serialiser
  assign word = kind_param ? param_word : cap_word;

  // Byte serialiser for both answers
  cqr_tx_ser i_ser (
    .clock    (clock),
    .arst_n   (arst_n),
    .start    (start),
    .word     (word),
    .word_idx (word_idx),
    .done     (ser_done),
    .tx_ready (tx_ready),
    .tx       (tx)
  );

  // Write strobes, one per stored setting
  assign we_link       = reg_we && (reg_addr == cqr_pkg::REG_LINK);
  assign we_bcast      = reg_we && (reg_addr == cqr_pkg::REG_BCAST);
  assign we_flags      = reg_we && (reg_addr == cqr_pkg::REG_CFG_FLAGS);
  assign we_flow       = reg_we && (reg_addr == cqr_pkg::REG_FLOW);
  assign we_vlan_mode  = reg_we && (reg_addr == cqr_pkg::REG_VLAN_MODE);
  assign we_aen        = reg_we && (reg_addr == cqr_pkg::REG_AEN);
  assign we_mac_flags  = reg_we && (reg_addr == cqr_pkg::REG_MAC_FLAGS);
  assign we_vlan_flags = reg_we && (reg_addr == cqr_pkg::REG_VLAN_FLAGS);

  // Stored settings; unsupported bits never store and read zero
  cqr_cfg_reg #(.RST(cqr_pkg::RST_ZERO), .MASK(cqr_pkg::MASK_ALL)) i_link (
    .clock(clock), .arst_n(arst_n),
    .we(we_link), .wdata(reg_wdata), .q(cfg_link)
  );

  cqr_cfg_reg #(.RST(cqr_pkg::RST_ZERO), .MASK(cqr_pkg::CAP_BCAST)) i_bcast (
    .clock(clock), .arst_n(arst_n),
    .we(we_bcast), .wdata(reg_wdata), .q(cfg_bcast)
  );

  cqr_cfg_reg #(.RST(cqr_pkg::RST_ZERO), .MASK(cqr_pkg::MASK_CFG)) i_flags (
    .clock(clock), .arst_n(arst_n),
    .we(we_flags), .wdata(reg_wdata), .q(cfg_flags)
  );

  cqr_cfg_reg #(.RST(cqr_pkg::RST_ZERO), .MASK(cqr_pkg::MASK_FLOW)) i_flow (
    .clock(clock), .arst_n(arst_n),
    .we(we_flow), .wdata(reg_wdata), .q(cfg_flow)
  );

  cqr_cfg_reg #(.RST(cqr_pkg::RST_VLAN_MODE), .MASK(cqr_pkg::MASK_VLAN_MD)) i_vlan_mode (
    .clock(clock), .arst_n(arst_n),
    .we(we_vlan_mode), .wdata(reg_wdata), .q(cfg_vlan_mode)
  );

  cqr_cfg_reg #(.RST(cqr_pkg::RST_ZERO), .MASK(cqr_pkg::CAP_AEN)) i_aen (
    .clock(clock), .arst_n(arst_n),
    .we(we_aen), .wdata(reg_wdata), .q(cfg_aen)
  );

  cqr_cfg_reg #(.RST(cqr_pkg::RST_ZERO), .MASK(cqr_pkg::MASK_MAC)) i_mac_flags (
    .clock(clock), .arst_n(arst_n),
    .we(we_mac_flags), .wdata(reg_wdata), .q(cfg_mac_flags)
  );

  cqr_cfg_reg #(.RST(cqr_pkg::RST_ZERO), .MASK(cqr_pkg::MASK_VLAN_FL)) i_vlan_flags (
    .clock(clock), .arst_n(arst_n),
    .we(we_vlan_flags), .wdata(reg_wdata), .q(cfg_vlan_flags)
  );

  // Read decode; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      cqr_pkg::REG_LINK:       next_rdata = cfg_link;
      cqr_pkg::REG_BCAST:      next_rdata = cfg_bcast;
      cqr_pkg::REG_CFG_FLAGS:  next_rdata = cfg_flags;
      cqr_pkg::REG_FLOW:       next_rdata = cfg_flow;
      cqr_pkg::REG_VLAN_MODE:  next_rdata = cfg_vlan_mode;
      cqr_pkg::REG_AEN:        next_rdata = cfg_aen;
      cqr_pkg::REG_MAC_FLAGS:  next_rdata = cfg_mac_flags;
      cqr_pkg::REG_VLAN_FLAGS: next_rdata = cfg_vlan_flags;
      cqr_pkg::REG_COUNTS:     next_rdata = {cqr_pkg::CNT_VLAN, cqr_pkg::CNT_MIXED,
                                             cqr_pkg::CNT_MCAST, cqr_pkg::CNT_UCAST};
      cqr_pkg::REG_STATE:      next_rdata = {cap_count, param_count};
      default:                 next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_re ? next_rdata : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* cqr_chk.sv */
// Assertion checker on the response stream of the query responder
`timescale 1ns/1ps
`default_nettype none
module cqr_chk (
  // Clock and reset
  input wire logic             clock,
  input wire logic             arst_n,
  // Byte streams
  input wire cqr_pkg::cqr_rx_t rx,
  input wire logic             rx_ready,
  input wire logic             tx_ready,
  input wire cqr_pkg::cqr_tx_t tx
);
  logic [5:0] rp;
  logic [5:0] tp;
  logic [7:0] cmd;
  wire        sv  = tx.valid;
  wire        cap = (cmd == cqr_pkg::CMD_GET_CAP);
  // Byte positions of both streams and the last command seen
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rp  <= 6'h00;
      tp  <= 6'h00;
      cmd <= 8'h00;
    end else begin
      if (rx.valid && rx_ready) rp <= rx.last ? 6'h00 : rp + 6'h01;
      if (rx.valid && rx_ready && rp == 6'h04) cmd <= rx.data;
      if (tx.valid && tx_ready) tp <= tx.last ? 6'h00 : tp + 6'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_stall; tx.valid && !tx_ready; endsequence
  property p_hold; s_stall |=> tx.valid && $stable(tx.data); endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  property p_t16; sv && cap && tp == 6'h04 |-> tx.data == 8'h96; endproperty
  a_t16: assert property (p_t16) else $error("capability type wrong");
  property p_t17; sv && cmd == 8'h17 && tp == 6'h04 |-> tx.data == 8'h97; endproperty
  a_t17: assert property (p_t17) else $error("readback type wrong");
  property p_rc; sv && cap && tp[5:2] == 4'h4 |-> tx.data == 8'h00; endproperty
  a_rc: assert property (p_rc) else $error("response code not generic");
  property p_len; sv && cap && tx.last |-> tp == 6'h33; endproperty
  a_len: assert property (p_len) else $error("capability length wrong");
  property p_flg;
    sv && cap && tp[5:2] == 4'h5 |-> tx.data == 8'(cqr_pkg::CAP_FLAGS >> (8 * (3 - tp[1:0])));
  endproperty
  a_flg: assert property (p_flg) else $error("flag byte wrong");
  property p_vl; sv && cap && tp == 6'h28 |-> tx.data <= 8'h0F; endproperty
  a_vl: assert property (p_vl) else $error("vlan count too big");
  property p_vm; sv && cap && tp == 6'h2E |-> tx.data[0] && tx.data[7:3] == 5'h00; endproperty
  a_vm: assert property (p_vm) else $error("vlan mode byte wrong");
endmodule
bind cqr_top cqr_chk i_chk (.clock, .arst_n, .rx, .rx_ready, .tx_ready, .tx);
`default_nettype wire

/* cqr_mc_model.sv */
// Management controller model: sends requests and gathers responses
`timescale 1ns/1ps
`default_nettype none
module cqr_mc_model (
  // Clock
  input  wire logic             clock,
  // Request side
  output cqr_pkg::cqr_rx_t      rx,
  input  wire logic             rx_ready,
  // Response side
  input  wire cqr_pkg::cqr_tx_t tx,
  output logic                  tx_ready,
  // Stall every other cycle
  input  wire logic             slow
);
  logic [7:0] resp [0:63];
  int         n = 0;
  logic       fin = 1'b0;
  initial rx = '0;
  always @(posedge clock) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clock) begin
    if (tx.valid && tx_ready) begin
      resp[n[5:0]] <= tx.data;
      n            <= n + 1;
      fin          <= tx.last;
    end
  end
  task automatic send(input logic [7:0] cmd, input logic bad);
    n   <= 0;
    fin <= 1'b0;
    for (int i = 0; i < 46; i++) begin
      rx.valid <= 1'b1;
      rx.data  <= (i == 4) ? cmd : 8'(i);
      rx.last  <= (i == 45);
      rx.err   <= bad && (i == 45);
      @(posedge clock);
      while (!rx_ready) @(posedge clock);
    end
    rx <= {1'b0, ~rx.data, 2'b00};
  endtask
endmodule
`default_nettype wire

/* cqr_top_test.sv */
// Testbench for the capability query responder
`timescale 1ns/1ps
`default_nettype none
module cqr_top_test;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic slow = 1'b0;
  logic rx_ready, tx_ready;
  logic [31:0] reg_rdata;
  cqr_pkg::cqr_rx_t rx;
  cqr_pkg::cqr_tx_t tx;
  int errors = 0;
  int compares = 0;
  cqr_top i_dut (.clock, .arst_n, .rx, .rx_ready, .tx_ready, .tx,
    .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
  cqr_mc_model i_mc (.clock, .rx, .rx_ready, .tx, .tx_ready, .slow);
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic rg(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= we;
    reg_re    <= !we;
    @(posedge clock);
    reg_we    <= 1'b0;
    reg_re    <= 1'b0;
    #1;
  endtask
  task automatic wait_resp;
    for (int k = 0; k < 500 && !i_mc.fin; k++) @(posedge clock);
    #1;
  endtask
  task automatic t_regs;
    rg(1'b0, cqr_pkg::REG_VLAN_MODE, 32'h0000_0000);
    chk("vlan mode reset", cqr_pkg::RST_VLAN_MODE, reg_rdata);
    rg(1'b1, cqr_pkg::REG_CFG_FLAGS, 32'hFFFF_FFFF);
    rg(1'b0, cqr_pkg::REG_CFG_FLAGS, 32'h0000_0000);
    chk("cfg flags", cqr_pkg::MASK_CFG, reg_rdata);
    rg(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, reg_rdata);
    $display("t_regs done");
  endtask
  task automatic t_cap(input logic s);
    logic [223:0] v;
    v = {cqr_pkg::CAP_FLAGS, cqr_pkg::CAP_BCAST, cqr_pkg::CAP_MCAST, cqr_pkg::CAP_BUFFER,
      cqr_pkg::CAP_AEN, cqr_pkg::CNT_VLAN, cqr_pkg::CNT_MIXED, cqr_pkg::CNT_MCAST,
      cqr_pkg::CNT_UCAST, 16'h0000, cqr_pkg::CAP_VLAN_MODE, cqr_pkg::CAP_CHANNELS};
    @(posedge clock);
    slow <= s;
    i_mc.send(cqr_pkg::CMD_GET_CAP, 1'b0);
    wait_resp();
    chk("length", 32'd52, 32'(i_mc.n));
    chk("type", 32'h0000_0096, {24'h0, i_mc.resp[4]});
    for (int p = 16; p < 48; p++) begin
      chk("cap byte", (p < 20) ? 8'h00 : v[(47 - p) * 8 +: 8], {24'h0, i_mc.resp[p]});
    end
    $display("t_cap done");
  endtask
  task automatic t_par;
    i_mc.send(cqr_pkg::CMD_GET_PARAM, 1'b0);
    wait_resp();
    chk("readback type", 32'h0000_0097, {24'h0, i_mc.resp[4]});
    chk("header echo", 32'h0000_0005, {24'h0, i_mc.resp[5]});
    chk("readback flags", cqr_pkg::MASK_CFG & 32'h0000_00FF, {24'h0, i_mc.resp[39]});
    chk("readback vlan mode", cqr_pkg::RST_VLAN_MODE, {24'h0, i_mc.resp[40]});
    $display("t_par done");
  endtask
  task automatic t_err;
    i_mc.send(cqr_pkg::CMD_GET_CAP, 1'b1);
    repeat (200) @(posedge clock);
    chk("no reply", 32'd0, 32'(i_mc.n));
    $display("t_err done");
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    forever #10 clock = ~clock;
  end
  initial begin
    #400_000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_cap(1'b0);
    t_cap(1'b1);
    t_par();
    t_err();
    give_verdict();
  end
endmodule
`default_nettype wire
